// ### qwd_pkg.sv
// Shared constants and types for the quad wiper command decoder
`default_nettype none
package qwd_pkg;
    localparam int NPOT  = 4;
    localparam int NSLOT = 4;
    localparam int NTAP  = 64;
    // Device type code; value is arbitrary
    localparam logic [3:0] DEV_TYPE = 4'hA;
    // Opcodes in the upper nibble of the instruction byte, then bit counter positions
    localparam logic [3:0] OP_RD_WIPER        = 4'h9;
    localparam logic [3:0] OP_WR_WIPER        = 4'hA;
    localparam logic [3:0] OP_RD_PRESET       = 4'hB;
    localparam logic [3:0] OP_WR_PRESET       = 4'hC;
    localparam logic [3:0] OP_PRESET_TO_WIPER = 4'hD;
    localparam logic [3:0] OP_WIPER_TO_PRESET = 4'hE;
    localparam logic [3:0] OP_GLOBAL_TO_WIPER = 4'h1;
    localparam logic [3:0] OP_GLOBAL_TO_PRESET = 4'h8;
    localparam logic [3:0] OP_STEP            = 4'h2;
    localparam logic [3:0] ACK_SLOT           = 4'h8;
    localparam logic [3:0] LAST_DATA_BIT      = 4'h7;
    // Reset values and tap limits
    localparam logic [5:0] PRESET_RST = 6'h20;
    localparam logic [5:0] TAP_MAX    = 6'h3F;
    localparam logic [5:0] TAP_MIN    = 6'h00;
    localparam logic [7:0] SYNC_RST   = 8'hC0;
    // Timing
    localparam int CLK_MHZ          = 100;
    localparam int NV_PROG_MS       = 5;
    localparam int NV_PROG_CYC_DFLT = NV_PROG_MS * 1000 * CLK_MHZ;
    localparam int WIPER_SETTLE_NS  = 500;
    localparam int SETTLE_CYC       = (WIPER_SETTLE_NS * CLK_MHZ + 999) / 1000;
    localparam logic [7:0] SETTLE_LOAD = 8'(SETTLE_CYC - 1);

    typedef logic [5:0] qwd_wiper_t;

    typedef struct packed {
        logic [3:0] opcode;
        logic [1:0] preset_sel;
        logic [1:0] pot_sel;
    } qwd_instr_t;

    typedef struct packed {
        logic bit_val;
        logic toggle;
    } qwd_link_bit_t;

    typedef enum logic [2:0] {
        ST_IDLE    = 3'b000,
        ST_ADDR    = 3'b001,
        ST_INSTR   = 3'b011,
        ST_RXDATA  = 3'b010,
        ST_TX      = 3'b110,
        ST_STEP    = 3'b111,
        ST_WAITSTP = 3'b101
    } qwd_state_t;
endpackage
`default_nettype wire

// ### qwd_link_sampler.sv
// Serial clock domain bit sampler for the quad wiper command decoder
`default_nettype none
module qwd_link_sampler (
    input  wire logic                   scl_clk_i,
    input  wire logic                   rst_i,
    input  wire logic                   sda_i,
    output var  qwd_pkg::qwd_link_bit_t link_bit_o
);
    import qwd_pkg::*;

    // Serial clock may be idle during reset, so reset acts without it
    always_ff @(posedge scl_clk_i or posedge rst_i) begin
        if (rst_i) begin
            link_bit_o <= '0;
        end else begin
            link_bit_o.bit_val <= sda_i;
            link_bit_o.toggle  <= ~link_bit_o.toggle;
        end
    end
endmodule
`default_nettype wire

// ### qwd_decoder.sv
// Command decoder and wiper/preset store for a four channel potentiometer
`default_nettype none
// Function
// - First byte upper nibble must equal the device type code to proceed.
// - First byte low nibble must match board address pins, else ignored.
// - Instruction byte is opcode, preset select, then pot select.
// - Preset select bits index slots zero to three in binary.
// - Four 6-bit wiper registers, each decoded to one of 64 taps.
// - After reset each wiper loads from its first preset slot.
// - Sixteen 6-bit presets; each change is a program of at most 5 ms.
// - Opcode 1001 returns the selected wiper value.
// - Opcode 1010 writes the data byte into the selected wiper.
// - Opcode 1011 returns the selected preset.
// - Opcode 1100 programs the data byte into the selected preset.
// - Opcode 1101 copies the selected preset into its wiper.
// - Opcode 1110 copies the selected wiper into the chosen preset slot.
// - Opcode 0001 copies chosen slot into all four wipers at once.
// - Opcode 1000 copies all four wipers into the chosen slots.
// - Opcode 0010 enters stepping mode for the selected wiper.
// - Reads and writes use address, instruction, one data byte.
// - Transfers use address and instruction only, then stop.
// - Wiper to preset copy is a full program cycle.
// - Tap outputs follow a wiper change only after the settle delay.
// - Stepping with data high moves the wiper one tap up.
// - Stepping with data low moves the wiper one tap down.
// - During programming the address is not acknowledged.
// - Guard pin low refuses acknowledge of preset data and skips programming.
// - Acknowledge after a matching address, a valid instruction and each accepted data byte.
module qwd_decoder #(
    parameter int NV_PROG_CYCLES = qwd_pkg::NV_PROG_CYC_DFLT
) (
    input  wire logic                                     core_clk_i,
    input  wire logic                                     rst_i,
    input  wire logic                                     ce_i,
    input  wire logic                                     scl_clk_i,
    input  wire logic                                     sda_i,
    output logic                                          sda_o,
    output logic                                          sda_oe_o,
    input  wire logic [3:0]                               board_address_pins_i,
    input  wire logic                                     write_guard_n_i,
    output logic [qwd_pkg::NPOT-1:0][qwd_pkg::NTAP-1:0]   wiper_tap_o,
    output logic                                          nv_busy_o
);
    import qwd_pkg::*;
    qwd_link_bit_t link_bit;
    logic [7:0]    sync_meta, sync_q, tx_byte, settle_cnt;
    logic          scl_prev, sda_prev, tgl_prev, ack_now, armed, boot_load, dirty;
    qwd_state_t    state;
    logic [3:0]    bit_cnt;
    logic [6:0]    shift_q;
    logic [5:0]    pend_data;
    qwd_instr_t    instr_q;
    qwd_wiper_t    wiper [NPOT], nv_val [NPOT], snap [NPOT];
    qwd_wiper_t    preset [NPOT][NSLOT];
    logic [19:0]   nv_cnt;
    logic [NPOT-1:0] nv_mask;
    logic [1:0]    nv_slot;
    function automatic logic instr_ok(qwd_instr_t i);
        case (i.opcode)
            OP_RD_WIPER, OP_WR_WIPER, OP_STEP: instr_ok = (i.preset_sel == 2'b00);
            OP_RD_PRESET, OP_WR_PRESET, OP_PRESET_TO_WIPER, OP_WIPER_TO_PRESET: instr_ok = 1'b1;
            OP_GLOBAL_TO_WIPER, OP_GLOBAL_TO_PRESET: instr_ok = (i.pot_sel == 2'b00);
            default: instr_ok = 1'b0;
        endcase
    endfunction

    function automatic logic is_nv(logic [3:0] op);
        is_nv = (op == OP_WR_PRESET) || (op == OP_WIPER_TO_PRESET) || (op == OP_GLOBAL_TO_PRESET);
    endfunction

    function automatic qwd_wiper_t step_tap(qwd_wiper_t w, logic up);
        if (up) begin
            step_tap = (w == TAP_MAX) ? TAP_MAX : 6'(w + 6'h01);
        end else begin
            step_tap = (w == TAP_MIN) ? TAP_MIN : 6'(w - 6'h01);
        end
    endfunction

    function automatic logic [NTAP-1:0] tap_decode(qwd_wiper_t w);
        tap_decode = '0;
        tap_decode[w] = 1'b1;
    endfunction

    qwd_link_sampler u_link (
        .scl_clk_i  (scl_clk_i),
        .rst_i      (rst_i),
        .sda_i      (sda_i),
        .link_bit_o (link_bit)
    );
    // Pins and link toggle pass two flops before use
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            sync_meta <= SYNC_RST;
            sync_q    <= SYNC_RST;
            scl_prev  <= 1'b1;
            sda_prev  <= 1'b1;
            tgl_prev  <= 1'b0;
        end else if (ce_i) begin
            sync_meta <= {scl_clk_i, sda_i, board_address_pins_i, write_guard_n_i, link_bit.toggle};
            sync_q    <= sync_meta;
            scl_prev  <= sync_q[7];
            sda_prev  <= sync_q[6];
            tgl_prev  <= sync_q[0];
        end
    end
    logic       scl_s, sda_s, guard_s, start_ev, stop_ev, scl_fall, bit_ev;
    logic       byte_done, nv_done, nv_launch, step_ev;
    logic [3:0] addr_s;
    logic [7:0] new_byte;
    qwd_instr_t cur_instr;
    assign scl_s     = sync_q[7];
    assign sda_s     = sync_q[6];
    assign addr_s    = sync_q[5:2];
    assign guard_s   = sync_q[1];
    assign start_ev  = scl_s && scl_prev && sda_prev && !sda_s;
    assign stop_ev   = scl_s && scl_prev && !sda_prev && sda_s;
    assign scl_fall  = scl_prev && !scl_s;
    // Bit value is stable from the sampling edge until the next one
    assign bit_ev    = sync_q[0] ^ tgl_prev;
    assign new_byte  = {shift_q, link_bit.bit_val};
    assign cur_instr = qwd_instr_t'(new_byte);
    assign byte_done = bit_ev && (bit_cnt == LAST_DATA_BIT)
                       && (state == ST_ADDR || state == ST_INSTR || state == ST_RXDATA);
    assign step_ev   = scl_fall && (state == ST_STEP) && (bit_cnt == 4'h1);
    assign nv_done   = nv_busy_o && (nv_cnt == 20'h00000);
    assign nv_launch = stop_ev && (state == ST_WAITSTP) && armed && is_nv(instr_q.opcode)
                       && guard_s && !nv_busy_o;
    // Frame sequencing and acknowledge decisions
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            state     <= ST_IDLE;
            bit_cnt   <= 4'h0;
            shift_q   <= 7'h00;
            ack_now   <= 1'b0;
            armed     <= 1'b0;
            tx_byte   <= 8'h00;
            pend_data <= 6'h00;
            instr_q   <= '0;
        end else if (ce_i) begin
            if (start_ev) begin
                state   <= ST_ADDR;
                bit_cnt <= 4'h0;
                ack_now <= 1'b0;
                armed   <= 1'b0;
            end else if (stop_ev) begin
                state   <= ST_IDLE;
                ack_now <= 1'b0;
                armed   <= 1'b0;
            end else if (bit_ev && state != ST_IDLE) begin
                if (bit_cnt == ACK_SLOT) begin
                    bit_cnt <= 4'h0;
                    ack_now <= 1'b0;
                    if (state == ST_TX && !ack_now && link_bit.bit_val) begin
                        state <= ST_WAITSTP;
                    end
                end else begin
                    // Stepping only marks a pending step; a stop pulse never falls
                    bit_cnt <= (state == ST_STEP) ? 4'h1 : 4'(bit_cnt + 4'h1);
                    shift_q <= {shift_q[5:0], link_bit.bit_val};
                end
                if (byte_done) begin
                    case (state)
                        ST_ADDR: begin
                            if (new_byte[7:4] == DEV_TYPE && new_byte[3:0] == addr_s && !nv_busy_o) begin
                                ack_now <= 1'b1;
                                state   <= ST_INSTR;
                            end else begin
                                state   <= ST_IDLE;
                            end
                        end
                        ST_INSTR: begin
                            instr_q <= cur_instr;
                            if (instr_ok(cur_instr)) begin
                                ack_now <= 1'b1;
                                case (cur_instr.opcode)
                                    OP_RD_WIPER: begin
                                        state   <= ST_TX;
                                        tx_byte <= {2'b00, wiper[cur_instr.pot_sel]};
                                    end
                                    OP_RD_PRESET: begin
                                        state   <= ST_TX;
                                        tx_byte <= {2'b00, preset[cur_instr.pot_sel][cur_instr.preset_sel]};
                                    end
                                    OP_WR_WIPER, OP_WR_PRESET: state <= ST_RXDATA;
                                    OP_STEP: state <= ST_STEP;
                                    default: begin
                                        state <= ST_WAITSTP;
                                        armed <= 1'b1;
                                    end
                                endcase
                            end else begin
                                state <= ST_IDLE;
                            end
                        end
                        default: begin
                            state     <= ST_WAITSTP;
                            pend_data <= new_byte[5:0];
                            if (instr_q.opcode == OP_WR_PRESET && !guard_s) begin
                                ack_now <= 1'b0;
                            end else begin
                                ack_now <= 1'b1;
                                armed   <= (instr_q.opcode == OP_WR_PRESET);
                            end
                        end
                    endcase
                end
            end else if (step_ev) begin
                bit_cnt <= 4'h0;
            end
        end
    end
    // Open drain data line: acknowledge and read data
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            sda_o    <= 1'b0;
            sda_oe_o <= 1'b0;
        end else if (ce_i) begin
            sda_o <= 1'b0;
            if (start_ev || stop_ev) begin
                sda_oe_o <= 1'b0;
            end else if (scl_fall) begin
                if (bit_cnt == ACK_SLOT) begin
                    sda_oe_o <= ack_now;
                end else if (state == ST_TX) begin
                    sda_oe_o <= ~tx_byte[3'(LAST_DATA_BIT - bit_cnt)];
                end else begin
                    sda_oe_o <= 1'b0;
                end
            end
        end
    end

    // Wiper position registers
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            boot_load <= 1'b1;
            for (int p = 0; p < NPOT; p++) begin
                wiper[p] <= TAP_MIN;
            end
        end else if (ce_i) begin
            if (boot_load) begin
                boot_load <= 1'b0;
                for (int p = 0; p < NPOT; p++) begin
                    wiper[p] <= preset[p][0];
                end
            end else if (byte_done && state == ST_RXDATA && instr_q.opcode == OP_WR_WIPER) begin
                wiper[instr_q.pot_sel] <= new_byte[5:0];
            end else if (step_ev) begin
                wiper[instr_q.pot_sel] <= step_tap(wiper[instr_q.pot_sel], link_bit.bit_val);
            end else if (stop_ev && state == ST_WAITSTP && armed) begin
                if (instr_q.opcode == OP_PRESET_TO_WIPER) begin
                    wiper[instr_q.pot_sel] <= preset[instr_q.pot_sel][instr_q.preset_sel];
                end else if (instr_q.opcode == OP_GLOBAL_TO_WIPER) begin
                    for (int p = 0; p < NPOT; p++) begin
                        wiper[p] <= preset[p][instr_q.preset_sel];
                    end
                end
            end
        end
    end

    // Program cycle: values are captured at stop, stored at the end
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            nv_busy_o <= 1'b0;
            nv_cnt    <= 20'h00000;
            nv_mask   <= '0;
            nv_slot   <= 2'b00;
            for (int p = 0; p < NPOT; p++) begin
                nv_val[p] <= TAP_MIN;
            end
        end else if (ce_i) begin
            if (nv_launch) begin
                nv_busy_o <= 1'b1;
                nv_cnt    <= 20'(NV_PROG_CYCLES - 1);
                nv_slot   <= instr_q.preset_sel;
                for (int p = 0; p < NPOT; p++) begin
                    nv_mask[p] <= (instr_q.opcode == OP_GLOBAL_TO_PRESET) || (2'(p) == instr_q.pot_sel);
                    nv_val[p]  <= (instr_q.opcode == OP_WR_PRESET) ? pend_data : wiper[p];
                end
            end else if (nv_done) begin
                nv_busy_o <= 1'b0;
            end else if (nv_busy_o) begin
                nv_cnt <= 20'(nv_cnt - 20'h00001);
            end
        end
    end

    // Preset store
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            for (int p = 0; p < NPOT; p++) begin
                for (int s = 0; s < NSLOT; s++) begin
                    preset[p][s] <= PRESET_RST;
                end
            end
        end else if (ce_i && nv_done) begin
            for (int p = 0; p < NPOT; p++) begin
                if (nv_mask[p]) begin
                    preset[p][nv_slot] <= nv_val[p];
                end
            end
        end
    end

    // Tap outputs follow the wipers after the settle delay
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            wiper_tap_o <= '0;
            settle_cnt  <= SETTLE_LOAD;
            dirty       <= 1'b1;
            for (int p = 0; p < NPOT; p++) begin
                snap[p] <= TAP_MIN;
            end
        end else if (ce_i) begin
            if (snap != wiper) begin
                snap       <= wiper;
                settle_cnt <= SETTLE_LOAD;
                dirty      <= 1'b1;
            end else if (settle_cnt != 8'h00) begin
                settle_cnt <= 8'(settle_cnt - 8'h01);
            end else if (dirty) begin
                dirty <= 1'b0;
                for (int p = 0; p < NPOT; p++) begin
                    wiper_tap_o[p] <= tap_decode(snap[p]);
                end
            end
        end
    end

    // Checks
    logic [19:0] busy_len;
    always_ff @(posedge core_clk_i) begin
        if (rst_i || !nv_busy_o) begin
            busy_len <= 20'h00000;
        end else if (ce_i) begin
            busy_len <= 20'(busy_len + 20'h00001);
        end
    end
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    type_match_a: assert property (ce_i && byte_done && state == ST_ADDR && new_byte[7:4] != DEV_TYPE
        |=> state == ST_IDLE && !ack_now) else $error("foreign type code accepted");
    addr_match_a: assert property (ce_i && byte_done && state == ST_ADDR && new_byte[3:0] != addr_s
        |=> state == ST_IDLE) else $error("foreign address accepted");
    busy_nack_a: assert property (ce_i && byte_done && state == ST_ADDR && nv_busy_o
        |=> !ack_now) else $error("address acknowledged while programming");
    nv_length_a: assert property (ce_i && nv_done |-> busy_len == 20'(NV_PROG_CYCLES - 1))
        else $error("program cycle length wrong");
    guard_nack_a: assert property (ce_i && byte_done && state == ST_RXDATA
        && instr_q.opcode == OP_WR_PRESET && !guard_s |=> !ack_now && !armed)
        else $error("guarded preset data acknowledged");
    step_up_a: assert property (ce_i && step_ev && link_bit.bit_val && wiper[instr_q.pot_sel] != TAP_MAX
        |=> wiper[instr_q.pot_sel] == 6'($past(wiper[instr_q.pot_sel]) + 6'h01))
        else $error("step up did not advance one tap");
    step_sat_a: assert property (ce_i && step_ev && !link_bit.bit_val && wiper[instr_q.pot_sel] == TAP_MIN
        |=> wiper[instr_q.pot_sel] == TAP_MIN) else $error("step down wrapped");
    read_wiper_a: assert property (ce_i && byte_done && state == ST_INSTR && cur_instr.opcode == OP_RD_WIPER
        && cur_instr.preset_sel == 2'b00 |=> tx_byte == {2'b00, wiper[instr_q.pot_sel]})
        else $error("read data mismatch");
    ack_drive_a: assert property (ce_i && scl_fall && bit_cnt == ACK_SLOT && ack_now && !start_ev && !stop_ev
        |=> sda_oe_o) else $error("acknowledge not driven");

    read_cov_c: cover property (state == ST_TX ##[1:1000] stop_ev);
    step_cov_c: cover property (step_ev ##[1:1000] step_ev);
    prog_cov_c: cover property (nv_done);
endmodule
`default_nettype wire

// ### qwd_bus_master.sv
// Two-wire bus master model for the decoder's serial link
`default_nettype none
module qwd_bus_master (
    input  wire logic lclk_i,
    input  wire logic sda_i,
    output var  logic scl_o,
    output var  logic sda_low_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial scl_o = 1'b1;
    initial sda_low_o = 1'b0;
    task tk(input int n);
        repeat (n) @(posedge lclk_i);
    endtask
    task put(input logic b);
        sda_low_o <= ~b;
        tk(4);
        scl_o <= 1'b1;
        tk(8);
        scl_o <= 1'b0;
        tk(4);
    endtask
    task get(output logic b);
        sda_low_o <= 1'b0;
        tk(4);
        scl_o <= 1'b1;
        tk(4);
        b = sda_i;
        tk(4);
        scl_o <= 1'b0;
        tk(4);
    endtask
    task start_c();
        tk(1);
        sda_low_o <= 1'b1;
        tk(8);
        scl_o <= 1'b0;
        tk(4);
    endtask
    task stop_c();
        sda_low_o <= 1'b1;
        tk(4);
        scl_o <= 1'b1;
        tk(8);
        sda_low_o <= 1'b0;
        tk(8);
    endtask
    task wbyte(input logic [7:0] v, output logic ack);
        logic b;
        for (int i = 7; i >= 0; i--) put(v[i]);
        get(b);
        ack = ~b;
    endtask
    task rbyte(output logic [7:0] v);
        for (int i = 7; i >= 0; i--) get(v[i]);
        put(1'b1);
    endtask
endmodule
`default_nettype wire

// ### testbench.sv
// Self-checking bench for the quad wiper command decoder
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import qwd_pkg::*;
    localparam logic [3:0] BRD = 4'h6;
    localparam logic [7:0] ADR = {DEV_TYPE, BRD};
    logic clk = 1'b0;
    logic lclk = 1'b0;
    logic rst = 1'b1;
    logic wg_n = 1'b1;
    logic scl, m_low, sda_o, sda_oe, busy, ka, ki, k;
    logic [NPOT-1:0][NTAP-1:0] taps;
    logic [7:0] d;
    int failures = 0;
    int num_checks = 0;
    wire logic sda_w = ~(m_low | (sda_oe & ~sda_o));
    always #5 clk = ~clk;
    initial begin
        #3;
        forever #6 lclk = ~lclk;
    end
    qwd_bus_master u_m (.lclk_i(lclk), .sda_i(sda_w), .scl_o(scl), .sda_low_o(m_low));
    qwd_decoder #(.NV_PROG_CYCLES(400)) u_dut (
        .core_clk_i(clk), .rst_i(rst), .ce_i(1'b1), .scl_clk_i(scl), .sda_i(sda_w), .sda_o(sda_o),
        .sda_oe_o(sda_oe), .board_address_pins_i(BRD), .write_guard_n_i(wg_n), .wiper_tap_o(taps),
        .nv_busy_o(busy));
    task chk(input logic [63:0] s, input logic [63:0] e);
        num_checks++;
        if (s !== e) begin
            failures++;
            $display("CHECK FAILED t=%0t seen=%0h exp=%0h", $time, s, e);
        end
    endtask
    task end_sim();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task frame(input logic [7:0] a, input logic [7:0] ins);
        u_m.start_c();
        u_m.wbyte(a, ka);
        u_m.wbyte(ins, ki);
    endtask
    task cmd(input logic [7:0] ins);
        frame(ADR, ins);
        chk({ka, ki}, 2'b11);
    endtask
    task wr3(input logic [7:0] ins, input logic [7:0] v);
        cmd(ins);
        u_m.wbyte(v, k);
        u_m.stop_c();
    endtask
    task rd3(input logic [7:0] ins, input logic [7:0] e);
        cmd(ins);
        u_m.rbyte(d);
        u_m.stop_c();
        chk(d, e);
    endtask
    task xfr2(input logic [7:0] ins);
        cmd(ins);
        u_m.stop_c();
    endtask
    task settle();
        repeat (SETTLE_CYC + 10) @(posedge clk);
    endtask
    task idle();
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 1000) begin
            @(posedge clk);
            n++;
        end
        if (n == 1000) begin
            failures++;
            end_sim();
        end
    endtask
    task t_reset();
        settle();
        for (int p = 0; p < NPOT; p++) chk(taps[p], 64'h1 << PRESET_RST);
        chk(busy, 1'b0);
    endtask
    task t_addr();
        frame({DEV_TYPE, ~BRD}, 8'h90);
        u_m.stop_c();
        chk(ka, 1'b0);
        frame({DEV_TYPE ^ 4'h3, BRD}, 8'h90);
        u_m.stop_c();
        chk(ka, 1'b0);
        frame(ADR, {OP_RD_WIPER, 4'h4});
        u_m.stop_c();
        chk({ka, ki}, 2'b10);
    endtask
    task t_wiper();
        wr3({OP_WR_WIPER, 4'h1}, 8'hC5);
        chk(k, 1'b1);
        settle();
        chk(taps[1], 64'h1 << 5);
        rd3({OP_RD_WIPER, 4'h1}, 8'h05);
    endtask
    task t_prog();
        wr3({OP_WR_PRESET, 2'd3, 2'd2}, 8'hEA);
        chk(busy, 1'b1);
        u_m.start_c();
        u_m.wbyte(ADR, ka);
        u_m.stop_c();
        chk(ka, 1'b0);
        idle();
        rd3({OP_RD_PRESET, 2'd3, 2'd2}, 8'h2A);
        rd3({OP_RD_PRESET, 2'd0, 2'd2}, 8'h20);
    endtask
    task t_xfer();
        xfr2({OP_PRESET_TO_WIPER, 2'd3, 2'd2});
        settle();
        chk(taps[2], 64'h1 << 6'h2A);
        xfr2({OP_WIPER_TO_PRESET, 2'd1, 2'd1});
        chk(busy, 1'b1);
        idle();
        rd3({OP_RD_PRESET, 2'd1, 2'd1}, 8'h05);
    endtask
    task t_global();
        xfr2({OP_GLOBAL_TO_WIPER, 2'd1, 2'd0});
        settle();
        for (int p = 0; p < NPOT; p++) chk(taps[p], 64'h1 << (p == 1 ? 5 : 32));
        wr3({OP_WR_WIPER, 4'h3}, 8'h11);
        xfr2({OP_GLOBAL_TO_PRESET, 2'd2, 2'd0});
        idle();
        rd3({OP_RD_PRESET, 2'd2, 2'd3}, 8'h11);
        rd3({OP_RD_PRESET, 2'd2, 2'd1}, 8'h05);
    endtask
    task step(input logic [5:0] v0, input logic [3:0] dirs, input logic [7:0] e);
        wr3({OP_WR_WIPER, 4'h0}, {2'b00, v0});
        cmd({OP_STEP, 4'h0});
        for (int i = 3; i >= 0; i--) u_m.put(dirs[i]);
        u_m.stop_c();
        rd3({OP_RD_WIPER, 4'h0}, e);
    endtask
    task t_guard();
        @(posedge clk);
        wg_n <= 1'b0;
        wr3({OP_WR_PRESET, 2'd0, 2'd3}, 8'h07);
        chk({k, busy}, 2'b00);
        rd3({OP_RD_PRESET, 2'd0, 2'd3}, 8'h20);
        @(posedge clk);
        wg_n <= 1'b1;
    endtask
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_addr();
        t_wiper();
        t_prog();
        t_xfer();
        t_global();
        step(6'h20, 4'b1110, 8'h22);
        step(6'h3E, 4'b1111, 8'h3F);
        step(6'h01, 4'b0000, 8'h00);
        t_guard();
        end_sim();
    end
endmodule
`default_nettype wire
